// ==== rtl/fcd_flash_clock_options.sv ====
// Flash clock divider, options register, security state and backdoor key check.
// Assumes the nonvolatile options byte, key and sequencer signals are on clock_i.
// What the document requires of this block and its software
// [RULE1] Divider loaded flag reads only, resets clear, first divider write sets it.
// [RULE2] Prescale and divisor bits always readable, written once after reset only.
// [RULE3] Erase and program are blocked until the divider loaded flag is set.
// [RULE4] Prescale bit chooses bus clock or bus clock divided by eight.
// [RULE5] Selected clock is divided by divisor field plus one.
// [RULE6] Software keeps the flash clock between 150 kHz and 200 kHz.
// [RULE7] Each timing pulse lasts one flash clock period, 5 to 6.7 us.
// [RULE8] Operations are timed as a whole number of flash clock pulses.
// [RULE9] Software should use the tabulated prescale and divisor settings.
// [RULE10] Each reset copies the nonvolatile options byte into the options register.
// [RULE11] Options bits 5 to 2 read zero; register readable, writes ignored.
// [RULE12] Software reprograms the nonvolatile byte then resets to change options.
// [RULE13] Key enable bit gates backdoor unlock by an in-order eight byte match.
// [RULE14] Key bytes from background debug commands can never unlock the device.
// [RULE15] Redirection disable bit set turns interrupt vector redirection off.
// [RULE16] Security code 10 means unsecured, every other code means secured.
// [RULE17] While secured, unsecured sources cannot reach RAM or flash contents.
// [RULE18] Key match or blank check success sets the security code to 10.
// [RULE19] Blocked accesses ignore the write and return zero read data.
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module fcd_flash_clock_options #(
	parameter int OP_COUNT_W = 12
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [fcd_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [7:0] nonvolatile_options_byte_i,
	input wire logic [63:0] stored_backdoor_key_i,
	input wire logic key_access_i,
	input wire logic key_write_i,
	input wire logic [7:0] key_byte_i,
	input wire logic key_from_debug_i,
	input wire logic blank_check_pass_i,
	input wire logic op_start_i,
	input wire logic [OP_COUNT_W-1:0] op_pulses_i,
	output logic op_busy_o,
	output logic op_done_o,
	output logic program_erase_enable_o,
	output logic flash_tick_o,
	output logic clock_in_range_o,
	output logic secured_o,
	output logic backdoor_key_enable_o,
	output logic redirect_enable_o,
	input wire logic mem_write_i,
	input wire logic mem_read_i,
	input wire logic mem_unsecured_src_i,
	input wire logic [7:0] mem_rdata_raw_i,
	output logic mem_write_allow_o,
	output logic [7:0] mem_rdata_o
);
	import fcd_pkg::*;

	logic divider_loaded_flag_reg;
	logic prescale_by_eight_reg;
	logic [5:0] divisor_field_reg;
	logic [7:0] flash_options_reg;
	logic [2:0] prescale_count_reg;
	logic [5:0] divide_count_reg;
	logic divider_input_en;
	logic tick_reg;
	logic [3:0] key_count_reg;
	logic key_bad_reg;
	logic key_access_q_reg;
	logic key_unlock;
	logic [7:0] key_expected;
	logic [OP_COUNT_W-1:0] op_left_reg;
	logic op_done_reg;
	fcd_op_state_t op_state_reg;
	logic [9:0] period_cycles;
	logic [7:0] mem_rdata_reg;
	logic [7:0] rdata_reg;
	logic access_blocked;

	// Address decode used by both the write side and the read side
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Divider register
	////////////////////////////////////////////////////////////////////////////////

	// Loaded flag: any first write sets it, data bits are ignored
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
			divider_loaded_flag_reg <= 1'b0;
		else if (reg_write_i && hit(reg_addr_i, DIVIDER_OFFSET))
			divider_loaded_flag_reg <= 1'b1; // [RULE1]
	end

	// Settings are frozen after the first write so a runaway write cannot retime flash
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			prescale_by_eight_reg <= DIVIDER_RESET[PRESCALE_BIT];
			divisor_field_reg <= DIVIDER_RESET[DIVISOR_MSB:DIVISOR_LSB];
		end
		else if (reg_write_i && hit(reg_addr_i, DIVIDER_OFFSET) && !divider_loaded_flag_reg)
		begin
			prescale_by_eight_reg <= reg_wdata_i[PRESCALE_BIT]; // [RULE2]
			divisor_field_reg <= reg_wdata_i[DIVISOR_MSB:DIVISOR_LSB]; // [RULE2]
		end
	end

	// Sequencer may only start once the divider is set up
	assign program_erase_enable_o = divider_loaded_flag_reg; // [RULE3]

	////////////////////////////////////////////////////////////////////////////////
	// Flash timing clock
	////////////////////////////////////////////////////////////////////////////////

	// Optional divide-by-eight prescaler; held still until the divider is loaded
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i || !divider_loaded_flag_reg)
			prescale_count_reg <= 3'h0;
		else
			prescale_count_reg <= prescale_count_reg + 3'h1;
	end

	// Divider input enable: every bus cycle, or every eighth one
	assign divider_input_en = divider_loaded_flag_reg &&
		(!prescale_by_eight_reg || prescale_count_reg == PRESCALE_LAST); // [RULE4]

	// Divide by divisor plus one; tick marks the start of each flash clock period
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i || !divider_loaded_flag_reg)
		begin
			divide_count_reg <= 6'h00;
			tick_reg <= 1'b0;
		end
		else if (divider_input_en)
		begin
			if (divide_count_reg == divisor_field_reg)
			begin
				divide_count_reg <= 6'h00; // [RULE5]
				tick_reg <= 1'b1;
			end
			else
			begin
				divide_count_reg <= divide_count_reg + 6'h01;
				tick_reg <= 1'b0;
			end
		end
		else
			tick_reg <= 1'b0;
	end
	assign flash_tick_o = tick_reg;

	// Bus cycles per flash clock period, for the range indication and the tick period check
	assign period_cycles = (prescale_by_eight_reg ? 10'(PRESCALE_RATIO) : 10'h001) *
		(10'(divisor_field_reg) + 10'h001);
	// Software owns the range; this flag only reports whether the choice is legal
	assign clock_in_range_o = divider_loaded_flag_reg &&
		period_cycles >= PULSE_MIN_CYC_W && period_cycles <= PULSE_MAX_CYC_W; // [RULE6]

	////////////////////////////////////////////////////////////////////////////////
	// Operation timer for the program and erase sequencer
	////////////////////////////////////////////////////////////////////////////////

	// Counts whole timing pulses; a start while the divider is unloaded is dropped
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			op_state_reg <= FCD_OP_IDLE;
			op_left_reg <= '0;
			op_done_reg <= 1'b0;
		end
		else
		begin
			op_done_reg <= 1'b0;
			case (op_state_reg)
				FCD_OP_IDLE:
				begin
					if (op_start_i && divider_loaded_flag_reg && op_pulses_i != '0)
					begin
						op_left_reg <= op_pulses_i; // [RULE3]
						op_state_reg <= FCD_OP_RUN;
					end
				end
				FCD_OP_RUN:
				begin
					if (tick_reg)
					begin
						if (op_left_reg == OP_COUNT_W'(1))
						begin
							op_done_reg <= 1'b1; // [RULE8]
							op_state_reg <= FCD_OP_IDLE;
						end
						op_left_reg <= op_left_reg - OP_COUNT_W'(1); // [RULE7]
					end
				end
				default:
					op_state_reg <= FCD_OP_IDLE;
			endcase
		end
	end
	assign op_busy_o = (op_state_reg == FCD_OP_RUN);
	assign op_done_o = op_done_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Options register and security state
	////////////////////////////////////////////////////////////////////////////////

	// Loaded from the nonvolatile byte on every reset cycle; bus writes never reach it
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			flash_options_reg <= nonvolatile_options_byte_i; // [RULE10]
			flash_options_reg[RESERVED_MSB:RESERVED_LSB] <= 4'h0; // [RULE11]
		end
		else if (key_unlock || blank_check_pass_i)
			flash_options_reg[SEC_MSB:SEC_LSB] <= SEC_UNSECURED; // [RULE18]
	end

	assign backdoor_key_enable_o = flash_options_reg[KEY_ENABLE_BIT];
	assign redirect_enable_o = !flash_options_reg[REDIRECT_DIS_BIT]; // [RULE15]
	assign secured_o = (flash_options_reg[SEC_MSB:SEC_LSB] != SEC_UNSECURED); // [RULE16]

	////////////////////////////////////////////////////////////////////////////////
	// Backdoor key compare
	////////////////////////////////////////////////////////////////////////////////

	// Byte expected next; byte 0 sits in the low bits of the stored key
	assign key_expected = stored_backdoor_key_i[key_count_reg[2:0]*8 +: 8];

	// Any debug-sourced, wrong or extra byte poisons the whole session
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
		begin
			key_count_reg <= 4'h0;
			key_bad_reg <= 1'b0;
			key_access_q_reg <= 1'b0;
		end
		else
		begin
			key_access_q_reg <= key_access_i;
			if (key_access_q_reg && !key_access_i)
			begin
				key_count_reg <= 4'h0;
				key_bad_reg <= 1'b0;
			end
			else if (key_access_i && key_write_i)
			begin
				if (key_from_debug_i || key_count_reg == KEY_COUNT_FULL ||
					key_byte_i != key_expected)
					key_bad_reg <= 1'b1; // [RULE14]
				if (key_count_reg != KEY_COUNT_FULL)
					key_count_reg <= key_count_reg + 4'h1; // [RULE13]
			end
		end
	end

	// Unlock is judged when key access is switched off
	assign key_unlock = key_access_q_reg && !key_access_i && flash_options_reg[KEY_ENABLE_BIT] &&
		!key_bad_reg && key_count_reg == KEY_COUNT_FULL; // [RULE13]

	////////////////////////////////////////////////////////////////////////////////
	// Memory access gating
	////////////////////////////////////////////////////////////////////////////////

	assign access_blocked = secured_o && mem_unsecured_src_i; // [RULE17]
	assign mem_write_allow_o = mem_write_i && !access_blocked; // [RULE19]

	// Read data one cycle after the request, forced to zero when blocked
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i)
			mem_rdata_reg <= READ_ZERO;
		else if (mem_read_i)
			mem_rdata_reg <= access_blocked ? READ_ZERO : mem_rdata_raw_i; // [RULE19]
	end
	assign mem_rdata_o = mem_rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Register read port
	////////////////////////////////////////////////////////////////////////////////

	// Unmapped addresses read zero; data stands only in the cycle after the strobe
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i || !reg_read_i)
			rdata_reg <= READ_ZERO;
		else if (hit(reg_addr_i, DIVIDER_OFFSET))
			rdata_reg <= {divider_loaded_flag_reg, prescale_by_eight_reg, divisor_field_reg};
		else if (hit(reg_addr_i, OPTIONS_OFFSET))
			rdata_reg <= flash_options_reg; // [RULE11]
		else
			rdata_reg <= READ_ZERO;
	end
	assign reg_rdata_o = rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	// Cycles since the last flash tick, for the period check
	logic [9:0] since_tick_reg;
	logic tick_seen_reg;
	always_ff @(posedge clock_i)
	begin
		if (!resetn_i || !divider_loaded_flag_reg)
		begin
			since_tick_reg <= 10'h000;
			tick_seen_reg <= 1'b0;
		end
		else if (tick_reg)
		begin
			since_tick_reg <= 10'h001;
			tick_seen_reg <= 1'b1;
		end
		else
			since_tick_reg <= since_tick_reg + 10'h001;
	end

	sequence div_first_write_s;
		reg_write_i && hit(reg_addr_i, DIVIDER_OFFSET) && !divider_loaded_flag_reg;
	endsequence

	sequence key_debug_session_s;
		key_access_i && key_write_i && key_from_debug_i ##1 key_access_i [*1] ##1 !key_access_i;
	endsequence

	div_loaded_set_a: assert property (div_first_write_s |=> divider_loaded_flag_reg) // [RULE1]
		else $error("divider loaded flag not set by first write");
	div_write_once_a: assert property (reg_write_i && hit(reg_addr_i, DIVIDER_OFFSET) && // [RULE2]
		divider_loaded_flag_reg |=> $stable(divisor_field_reg) && $stable(prescale_by_eight_reg))
		else $error("divider settings changed by second write");
	op_gate_a: assert property (!divider_loaded_flag_reg && op_start_i |=> !op_busy_o) // [RULE3]
		else $error("operation started with divider unloaded");
	tick_period_a: assert property (tick_reg && tick_seen_reg && $past(tick_seen_reg) |-> // [RULE5]
		since_tick_reg == period_cycles)
		else $error("flash tick period wrong");
	op_whole_pulses_a: assert property (op_done_reg |-> $past(tick_reg)) // [RULE8]
		else $error("operation ended off a pulse boundary");
	opt_write_ignored_a: assert property (hit(reg_addr_i, OPTIONS_OFFSET) && // [RULE11]
		reg_write_i && !key_unlock && !blank_check_pass_i |=> $stable(flash_options_reg))
		else $error("options register changed by write");
	opt_reserved_zero_a: assert property (reg_read_i && // [RULE11]
		hit(reg_addr_i, OPTIONS_OFFSET) |=> reg_rdata_o[RESERVED_MSB:RESERVED_LSB] == 4'h0)
		else $error("options reserved bits not zero");
	opt_steady_a: assert property ($stable({redirect_enable_o, backdoor_key_enable_o})) // [RULE11]
		else $error("option bits changed without reset");
	debug_key_a: assert property (key_debug_session_s |-> !key_unlock) // [RULE14]
		else $error("debug key bytes unlocked device");
	blank_unsecure_a: assert property (blank_check_pass_i |=> !secured_o) // [RULE18]
		else $error("blank check did not unsecure");
	blocked_read_a: assert property (mem_read_i && secured_o && mem_unsecured_src_i |=> // [RULE19]
		mem_rdata_o == READ_ZERO)
		else $error("blocked read returned data");
	blocked_write_a: assert property (secured_o && mem_unsecured_src_i |-> !mem_write_allow_o) // [RULE17]
		else $error("blocked write passed");
endmodule
`default_nettype wire

// ==== rtl/fcd_pkg.sv ====
// Constants shared by the flash clock divider and options block.
// Assumes a single bus clock; offsets are word indices on a plain port.
package fcd_pkg;
	// Register addresses on the plain register port
	localparam int ADDR_W = 2;
	localparam logic [ADDR_W-1:0] DIVIDER_OFFSET = 2'h0;
	localparam logic [ADDR_W-1:0] OPTIONS_OFFSET = 2'h1;
	// Divider register field positions
	localparam int LOADED_BIT = 7;
	localparam int PRESCALE_BIT = 6;
	localparam int DIVISOR_MSB = 5;
	localparam int DIVISOR_LSB = 0;
	// Options register field positions
	localparam int KEY_ENABLE_BIT = 7;
	localparam int REDIRECT_DIS_BIT = 6;
	localparam int RESERVED_MSB = 5;
	localparam int RESERVED_LSB = 2;
	localparam int SEC_MSB = 1;
	localparam int SEC_LSB = 0;
	localparam logic [1:0] SEC_UNSECURED = 2'h2;
	// Values after reset
	localparam logic [6:0] DIVIDER_RESET = 7'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	// Prescaler ratio when the divide-by-eight option is on
	localparam int PRESCALE_RATIO = 8;
	localparam logic [2:0] PRESCALE_LAST = 3'h7;
	// Backdoor key length in bytes
	localparam int KEY_BYTES = 8;
	localparam logic [3:0] KEY_COUNT_FULL = 4'h8;
	// Timing pulse window and bus clock rate
	localparam int CLOCK_KHZ = 40000;
	localparam int PULSE_MIN_NS = 5000;
	localparam int PULSE_MAX_NS = 6700;
	localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * CLOCK_KHZ + 999999) / 1000000;
	localparam int PULSE_MAX_CYC = (PULSE_MAX_NS * CLOCK_KHZ) / 1000000;
	localparam logic [9:0] PULSE_MIN_CYC_W = PULSE_MIN_CYC[9:0];
	localparam logic [9:0] PULSE_MAX_CYC_W = PULSE_MAX_CYC[9:0];
	// Operation timer states
	typedef enum logic [1:0] {
		FCD_OP_IDLE = 2'b01,
		FCD_OP_RUN = 2'b10
	} fcd_op_state_t;
endpackage

// ==== testbench/tb_fcd_flash_clock_options.sv ====
// Self-checking bench for the flash clock divider and options block.
// Assumes the design package is compiled first; the bench drives every design input itself.
`timescale 1ns/1ps
`default_nettype none
module tb_fcd_flash_clock_options;
	import fcd_pkg::*;
	logic clock_i, resetn_i, reg_write_i, reg_read_i, key_access_i, key_write_i;
	logic key_from_debug_i, blank_check_pass_i, op_start_i, mem_write_i, mem_read_i;
	logic mem_unsecured_src_i, op_busy_o, op_done_o, program_erase_enable_o, flash_tick_o;
	logic clock_in_range_o, secured_o, backdoor_key_enable_o, redirect_enable_o;
	logic mem_write_allow_o, rd_q;
	logic [ADDR_W-1:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, nonvolatile_options_byte_i, key_byte_i;
	logic [7:0] mem_rdata_raw_i, mem_rdata_o, nv;
	logic [11:0] op_pulses_i;
	logic [63:0] stored_backdoor_key_i, key;
	logic [7:0] rd_exp[$];
	logic [7:0] dv[4] = '{8'h00, 8'h27, 8'h4c, 8'h58};
	int gp[4] = '{1, 40, 104, 200};
	int fails = 0;
	int checks_done = 0;
	int cyc = 0;
	int i, n;
	fcd_flash_clock_options #(.OP_COUNT_W(12)) u_fcd_flash_clock_options (.clock_i(clock_i),
		.resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
		.nonvolatile_options_byte_i(nonvolatile_options_byte_i),
		.stored_backdoor_key_i(stored_backdoor_key_i), .key_access_i(key_access_i),
		.key_write_i(key_write_i), .key_byte_i(key_byte_i), .key_from_debug_i(key_from_debug_i),
		.blank_check_pass_i(blank_check_pass_i), .op_start_i(op_start_i),
		.op_pulses_i(op_pulses_i), .op_busy_o(op_busy_o), .op_done_o(op_done_o),
		.program_erase_enable_o(program_erase_enable_o), .flash_tick_o(flash_tick_o),
		.clock_in_range_o(clock_in_range_o), .secured_o(secured_o),
		.backdoor_key_enable_o(backdoor_key_enable_o), .redirect_enable_o(redirect_enable_o),
		.mem_write_i(mem_write_i), .mem_read_i(mem_read_i),
		.mem_unsecured_src_i(mem_unsecured_src_i), .mem_rdata_raw_i(mem_rdata_raw_i),
		.mem_write_allow_o(mem_write_allow_o), .mem_rdata_o(mem_rdata_o));
	////////////////////////////////////////////////////////////////////////////////
	// 40 MHz bus clock
	always #12.5 clock_i = ~clock_i;
	// Hang guard, well above the longest expected run
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fails++;
			results();
		end
	end
	// Read data stands only in the cycle after the strobe, so sample it mid-cycle there
	always @(posedge clock_i) rd_q <= reg_read_i;
	always @(negedge clock_i)
		if (rd_q && rd_exp.size() > 0)
			check(reg_rdata_o, rd_exp.pop_front());
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One bus cycle; strobes stay up until the next call or idle, so no double assignment
	task automatic bus(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
		reg_write_i <= w;
		reg_read_i <= r;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		rd_exp.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	task automatic idle();
		bus(1'b0, 1'b0, 2'h0, 8'h00);
	endtask
	task automatic rst(input logic [7:0] b);
		resetn_i <= 1'b0;
		nonvolatile_options_byte_i <= b;
		repeat (12) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
	endtask
	// Cycles between two consecutive flash ticks
	task automatic tick_gap(input int exp);
		int k;
		k = 0;
		while (flash_tick_o !== 1'b1 && k < 3000)
		begin
			@(posedge clock_i);
			#1 k++;
		end
		k = 0;
		do
		begin
			@(posedge clock_i);
			#1 k++;
		end while (flash_tick_o !== 1'b1 && k < 3000);
		check(k, exp);
	endtask
	// Timed operation: ticks seen while busy must equal the requested pulse count
	task automatic op_run(input int p);
		int t;
		t = 0;
		op_start_i <= 1'b1;
		op_pulses_i <= p[11:0];
		@(posedge clock_i);
		op_start_i <= 1'b0;
		repeat (3000)
		begin
			#1;
			if (flash_tick_o === 1'b1 && op_busy_o === 1'b1)
				t++;
			if (op_done_o === 1'b1)
				break;
			@(posedge clock_i);
		end
		check(t, p);
		check({op_done_o, op_busy_o}, 2'b10);
		@(posedge clock_i);
	endtask
	// Backdoor session; bad 1 sends the last byte from debug, bad 2 corrupts one byte
	// The debug byte goes last so the session closes right after it, where the guard looks
	task automatic key_try(input logic en, input int bad, input logic sec);
		rst({en, 7'h03});
		key_access_i <= 1'b1;
		@(posedge clock_i);
		for (int j = 0; j < 8; j++)
		begin
			key_byte_i <= key[8*j +: 8] ^ ((bad == 2 && j == 5) ? 8'h10 : 8'h00);
			key_from_debug_i <= (bad == 1 && j == 7);
			key_write_i <= 1'b1;
			@(posedge clock_i);
			key_write_i <= 1'b0;
			@(posedge clock_i);
		end
		key_access_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		#1 check(secured_o, sec);
		@(posedge clock_i);
		rd(2'h1, {en, 5'h00, sec ? 2'b11 : 2'b10});
		idle();
	endtask
	// Memory gate for both kinds of source
	task automatic mem_try(input logic sec);
		logic [7:0] r;
		for (int s = 0; s < 2; s++)
		begin
			r = 8'($urandom_range(1, 255));
			mem_unsecured_src_i <= s[0];
			mem_rdata_raw_i <= r;
			mem_write_i <= 1'b1;
			mem_read_i <= 1'b1;
			#1 check(mem_write_allow_o, !(sec && s == 1));
			@(posedge clock_i);
			mem_write_i <= 1'b0;
			mem_read_i <= 1'b0;
			#1 check(mem_rdata_o, (sec && s == 1) ? 8'h00 : r);
			@(posedge clock_i);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		clock_i = 1'b0;
		{resetn_i, reg_write_i, reg_read_i, key_access_i, key_write_i} = 5'h00;
		{key_from_debug_i, blank_check_pass_i, op_start_i, mem_write_i, mem_read_i} = 5'h00;
		{mem_unsecured_src_i, reg_addr_i, reg_wdata_i, key_byte_i} = 19'h00000;
		{nonvolatile_options_byte_i, mem_rdata_raw_i, op_pulses_i} = 28'h0000000;
		void'($urandom(32'h072a));
		key = {$urandom, $urandom};
		stored_backdoor_key_i = key;
		// Every security code, with random option bits and random reserved bits
		for (i = 0; i < 4; i++)
		begin
			nv = 8'($urandom);
			nv[1:0] = i[1:0];
			rst(nv);
			#1 check(secured_o, i != 2);
			check(backdoor_key_enable_o, nv[7]);
			check(redirect_enable_o, !nv[6]);
			@(posedge clock_i);
			rd(2'h1, nv & 8'hc3);
			wr(2'h1, ~nv);
			rd(2'h1, nv & 8'hc3);
			rd(2'h2, 8'h00);
			rd(2'h3, 8'h00);
			idle();
		end
		// Divider settings: unloaded blocking, write-once, tick period, timed operation
		for (i = 0; i < 4; i++)
		begin
			rst(8'h82);
			rd(2'h0, 8'h00);
			op_start_i <= 1'b1;
			op_pulses_i <= 12'h001;
			idle();
			op_start_i <= 1'b0;
			#1 check(op_busy_o, 1'b0);
			check(program_erase_enable_o, 1'b0);
			n = 0;
			repeat (30)
			begin
				@(posedge clock_i);
				#1 n += (flash_tick_o !== 1'b0);
			end
			check(n, 0);
			@(posedge clock_i);
			wr(2'h0, dv[i]);
			wr(2'h0, ~dv[i]);
			rd(2'h0, {1'b1, dv[i][6:0]});
			idle();
			#1 check(program_erase_enable_o, 1'b1);
			tick_gap(gp[i]);
			check(clock_in_range_o, gp[i] >= 200 && gp[i] <= 268);
			@(posedge clock_i);
			op_run($urandom_range(1, 5));
		end
		// Backdoor key, memory gate and blank check
		key_try(1'b1, 0, 1'b0);
		mem_try(1'b0);
		key_try(1'b1, 1, 1'b1);
		key_try(1'b1, 2, 1'b1);
		key_try(1'b0, 0, 1'b1);
		mem_try(1'b1);
		blank_check_pass_i <= 1'b1;
		@(posedge clock_i);
		blank_check_pass_i <= 1'b0;
		#1 check(secured_o, 1'b0);
		@(posedge clock_i);
		rd(2'h1, 8'h02);
		idle();
		mem_try(1'b0);
		repeat (4) @(posedge clock_i);
		results();
	end
endmodule
`default_nettype wire
